/* File: fault_pkg.sv */
package fault_pkg;
   localparam int CLOCK_HZ = 20000000;
   // Overcurrent off-time
   localparam int OC_WAIT_MS = 12;
   localparam int OC_WAIT_CYCLES = (CLOCK_HZ / 1000) * OC_WAIT_MS;
   localparam int RETRY_LIMIT = 7;
   localparam int RETRY_W = 3;
   localparam int WAIT_W = 18;
   // Comparator levels carried as constants for reference
   localparam int OCP_NOMINAL_UA = 100;
   localparam int OCP_SOFTSTART_UA = 140;
   localparam int UV_TRIP_MV = 300;
   localparam int UV_RELEASE_MV = 250;
   localparam int OV_CLAMP_RELEASE_MV = 400;
   localparam logic [1:0] PHASE_DRIVE_LOW = 2'h0;
   localparam logic [1:0] PHASE_DRIVE_HIZ = 2'h1;
   localparam logic [1:0] PHASE_DRIVE_RUN = 2'h2;
endpackage

/* File: oc_retry.sv */
`timescale 1ns/1ps
`default_nettype none
module oc_retry
   import fault_pkg::*;
#(
   parameter int WAIT_CYCLES = OC_WAIT_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic trip,
   input wire logic ss_done,
   input wire logic enabled,
   output logic shut,
   output logic restart,
   output logic exhausted
);
   logic [WAIT_W-1:0] wait_count;
   logic [RETRY_W-1:0] retries;

   always_ff @(posedge clk) begin
      if (rst) begin
         shut <= 1'b0;
         wait_count <= '0;
         restart <= 1'b0;
      end else begin
         restart <= 1'b0;
         if (!shut && trip && !exhausted) begin
            shut <= 1'b1;
            wait_count <= WAIT_W'(WAIT_CYCLES - 1);
         end else if (shut && !exhausted) begin
            if (wait_count != '0) begin
               wait_count <= wait_count - 1'b1;
            end else if (enabled) begin
               shut <= 1'b0;
               restart <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         retries <= '0;
         exhausted <= 1'b0;
      end else if (!shut && trip && !exhausted) begin
         // Trip as soft-start completes: count restarts from this trip
         if (ss_done)
            retries <= RETRY_W'(1);
         else if (retries == RETRY_W'(RETRY_LIMIT))
            exhausted <= 1'b1;
         else
            retries <= retries + 1'b1;
      end else if (ss_done) begin
         retries <= '0;
      end
   end

   property p_wait_len;
      @(posedge clk) disable iff (rst)
      $rose(shut) |-> shut [*8];
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("off period too short");

   property p_exhaust_hold;
      @(posedge clk) disable iff (rst)
      exhausted |=> exhausted && !restart;
   endproperty
   a_exhaust_hold: assert property (p_exhaust_hold) else $error("latch-off released");

   property p_restart_enabled;
      @(posedge clk) disable iff (rst)
      restart |-> $past(enabled);
   endproperty
   a_restart_enabled: assert property (p_restart_enabled) else $error("restart while disabled");
endmodule
`default_nettype wire

/* File: pg_hyst.sv */
`timescale 1ns/1ps
`default_nettype none
module pg_hyst
   import fault_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic below_uv,
   input wire logic above_release,
   output logic in_window
);
   always_ff @(posedge clk) begin
      if (rst)
         in_window <= 1'b0;
      else if (below_uv)
         in_window <= 1'b0;
      else if (above_release)
         in_window <= 1'b1;
   end

   property p_uv_low;
      @(posedge clk) disable iff (rst)
      below_uv |=> !in_window;
   endproperty
   a_uv_low: assert property (p_uv_low) else $error("good kept during undervoltage");

   property p_release;
      @(posedge clk) disable iff (rst)
      !in_window && !above_release |=> !in_window;
   endproperty
   a_release: assert property (p_release) else $error("release without hysteresis");
endmodule
`default_nettype wire

/* File: regulator_fault_protection.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_protection
   import fault_pkg::*;
#(
   parameter int WAIT_CYCLES = OC_WAIT_CYCLES
) (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // Supply status
   input wire logic MAIN_POR_OK,
   input wire logic DRIVER_SUPPLY_OK,
   input wire logic ENABLE,
   // Soft-start progress per rail
   input wire logic CORE_SS_DONE,
   input wire logic NB_SS_DONE,
   // Voltage comparators per rail
   input wire logic CORE_OVERVOLTAGE_TRIP,
   input wire logic CORE_ABOVE_PG_UPPER,
   input wire logic CORE_DIFF_ABOVE_400MV,
   input wire logic CORE_BELOW_UV,
   input wire logic CORE_ABOVE_UV_RELEASE,
   input wire logic NB_OVERVOLTAGE_TRIP,
   input wire logic NB_ABOVE_PG_UPPER,
   input wire logic NB_DIFF_ABOVE_400MV,
   input wire logic NB_BELOW_UV,
   input wire logic NB_ABOVE_UV_RELEASE,
   input wire logic OPEN_SENSE,
   // Current comparators: nominal and raised level per rail
   input wire logic CORE_CURRENT_ABOVE_100UA,
   input wire logic CORE_CURRENT_ABOVE_140UA,
   input wire logic NB_CURRENT_ABOVE_100UA,
   input wire logic NB_CURRENT_ABOVE_140UA,
   // Phase three/four populated
   input wire logic PHASE_THREE_ACTIVE,
   input wire logic PHASE_FOUR_ACTIVE,
   // Drive commands
   output logic CORE_SWITCH_ENABLE,
   output logic CORE_LOW_SIDE_FORCE_ON,
   output logic NB_SWITCH_ENABLE,
   output logic NB_LOW_SIDE_FORCE_ON,
   output logic [1:0] EXT_PHASE_THREE_DRIVE,
   output logic [1:0] EXT_PHASE_FOUR_DRIVE,
   output logic CORE_SOFT_START_REQ,
   output logic NB_SOFT_START_REQ,
   output logic PRE_POR_OVP_ENABLE,
   output logic POWER_GOOD_OUT
);
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_SOFTSTART = 5'h02,
      ST_RUN = 5'h04,
      ST_SENSE_OPEN = 5'h08,
      ST_LATCHED = 5'h10
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;
   logic ov_latched;
   logic core_ov, nb_ov, core_clamp, nb_clamp;
   logic supplies_ok;
   logic core_trip, nb_trip;
   logic core_shut, nb_shut, core_restart, nb_restart, core_exh, nb_exh;
   logic core_good, nb_good;
   logic in_ss;

   function automatic logic oc_trip(input logic ss, input logic above_nom, input logic above_raised);
      oc_trip = ss ? above_raised : above_nom;
   endfunction

   assign supplies_ok = MAIN_POR_OK && DRIVER_SUPPLY_OK;
   assign in_ss = (state == ST_SOFTSTART);
   assign core_ov = CORE_OVERVOLTAGE_TRIP && CORE_ABOVE_PG_UPPER;
   assign nb_ov = NB_OVERVOLTAGE_TRIP && NB_ABOVE_PG_UPPER;
   assign core_trip = (in_ss || state == ST_RUN) && !core_shut
      && oc_trip(in_ss && !CORE_SS_DONE, CORE_CURRENT_ABOVE_100UA, CORE_CURRENT_ABOVE_140UA);
   assign nb_trip = (in_ss || state == ST_RUN) && !nb_shut
      && oc_trip(in_ss && !NB_SS_DONE, NB_CURRENT_ABOVE_100UA, NB_CURRENT_ABOVE_140UA);

   oc_retry #(.WAIT_CYCLES(WAIT_CYCLES)) u_core_oc (
      .clk(CLOCK),
      .rst(RST || !MAIN_POR_OK),
      .trip(core_trip),
      .ss_done(in_ss && CORE_SS_DONE && NB_SS_DONE),
      .enabled(ENABLE),
      .shut(core_shut),
      .restart(core_restart),
      .exhausted(core_exh)
   );

   oc_retry #(.WAIT_CYCLES(WAIT_CYCLES)) u_nb_oc (
      .clk(CLOCK),
      .rst(RST || !MAIN_POR_OK),
      .trip(nb_trip),
      .ss_done(in_ss && CORE_SS_DONE && NB_SS_DONE),
      .enabled(ENABLE),
      .shut(nb_shut),
      .restart(nb_restart),
      .exhausted(nb_exh)
   );

   pg_hyst u_core_pg (
      .clk(CLOCK),
      .rst(RST),
      .below_uv(CORE_BELOW_UV),
      .above_release(CORE_ABOVE_UV_RELEASE),
      .in_window(core_good)
   );

   pg_hyst u_nb_pg (
      .clk(CLOCK),
      .rst(RST),
      .below_uv(NB_BELOW_UV),
      .above_release(NB_ABOVE_UV_RELEASE),
      .in_window(nb_good)
   );

   always_ff @(posedge CLOCK) begin
      if (RST)
         ov_latched <= 1'b0;
      else if (!MAIN_POR_OK)
         ov_latched <= 1'b0;
      else if (core_ov || nb_ov)
         ov_latched <= 1'b1;
   end

   // clamp until differential below 400mV, re-arms on recurrence
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         core_clamp <= 1'b0;
         nb_clamp <= 1'b0;
      end else begin
         if (core_ov)
            core_clamp <= 1'b1;
         else if (!CORE_DIFF_ABOVE_400MV)
            core_clamp <= 1'b0;
         if (nb_ov)
            nb_clamp <= 1'b1;
         else if (!NB_DIFF_ABOVE_400MV)
            nb_clamp <= 1'b0;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (supplies_ok && ENABLE)
               next_state = ST_SOFTSTART;
         end
         ST_SOFTSTART: begin
            if (CORE_SS_DONE && NB_SS_DONE && !core_shut && !nb_shut)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         ST_SENSE_OPEN: begin
            // restart once the line is back
            if (!OPEN_SENSE)
               next_state = ST_OFF;
         end
         ST_LATCHED: begin
            next_state = ST_LATCHED;
         end
         default: begin
            next_state = ST_OFF;
         end
      endcase
      if (state != ST_LATCHED && state != ST_SENSE_OPEN && (core_restart || nb_restart))
         next_state = ST_SOFTSTART;
      if (state != ST_LATCHED && OPEN_SENSE)
         next_state = ST_SENSE_OPEN;
      if (!supplies_ok || !ENABLE)
         next_state = ST_OFF;
      if (ov_latched || core_ov || nb_ov || core_exh || nb_exh)
         next_state = ST_LATCHED;
      if (!MAIN_POR_OK)
         next_state = ST_OFF;
   end

   always_ff @(posedge CLOCK) begin
      if (RST)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CORE_SWITCH_ENABLE <= 1'b0;
         NB_SWITCH_ENABLE <= 1'b0;
         CORE_LOW_SIDE_FORCE_ON <= 1'b0;
         NB_LOW_SIDE_FORCE_ON <= 1'b0;
         EXT_PHASE_THREE_DRIVE <= PHASE_DRIVE_HIZ;
         EXT_PHASE_FOUR_DRIVE <= PHASE_DRIVE_HIZ;
      end else begin
         CORE_SWITCH_ENABLE <= (next_state == ST_SOFTSTART || next_state == ST_RUN) && !core_shut && !core_trip;
         NB_SWITCH_ENABLE <= (next_state == ST_SOFTSTART || next_state == ST_RUN) && !nb_shut && !nb_trip;
         CORE_LOW_SIDE_FORCE_ON <= core_ov || core_clamp;
         NB_LOW_SIDE_FORCE_ON <= nb_ov || nb_clamp;
         if ((core_ov || core_clamp) && PHASE_THREE_ACTIVE)
            EXT_PHASE_THREE_DRIVE <= PHASE_DRIVE_LOW;
         else if (PHASE_THREE_ACTIVE && (next_state == ST_SOFTSTART || next_state == ST_RUN)
                  && !core_shut && !core_trip)
            EXT_PHASE_THREE_DRIVE <= PHASE_DRIVE_RUN;
         else
            EXT_PHASE_THREE_DRIVE <= PHASE_DRIVE_HIZ;
         if ((core_ov || core_clamp) && PHASE_FOUR_ACTIVE)
            EXT_PHASE_FOUR_DRIVE <= PHASE_DRIVE_LOW;
         else if (PHASE_FOUR_ACTIVE && (next_state == ST_SOFTSTART || next_state == ST_RUN)
                  && !core_shut && !core_trip)
            EXT_PHASE_FOUR_DRIVE <= PHASE_DRIVE_RUN;
         else
            EXT_PHASE_FOUR_DRIVE <= PHASE_DRIVE_HIZ;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST)
         PRE_POR_OVP_ENABLE <= 1'b1;
      else
         PRE_POR_OVP_ENABLE <= !supplies_ok;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CORE_SOFT_START_REQ <= 1'b0;
         NB_SOFT_START_REQ <= 1'b0;
      end else begin
         CORE_SOFT_START_REQ <= (next_state == ST_SOFTSTART) && !core_shut;
         NB_SOFT_START_REQ <= (next_state == ST_SOFTSTART) && !nb_shut;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST)
         POWER_GOOD_OUT <= 1'b0;
      else
         POWER_GOOD_OUT <= (next_state == ST_RUN) && core_good && nb_good && !CORE_BELOW_UV && !NB_BELOW_UV
            && !core_ov && !nb_ov && !core_shut && !nb_shut && !core_trip && !nb_trip;
   end

   property p_ov_response;
      @(posedge CLOCK) disable iff (RST)
      core_ov |=> CORE_LOW_SIDE_FORCE_ON && !CORE_SWITCH_ENABLE && !POWER_GOOD_OUT;
   endproperty
   a_ov_response: assert property (p_ov_response) else $error("overvoltage response missing");

   property p_ov_latch;
      @(posedge CLOCK) disable iff (RST)
      ov_latched && MAIN_POR_OK |=> state == ST_LATCHED;
   endproperty
   a_ov_latch: assert property (p_ov_latch) else $error("overvoltage latch left");

   property p_core_oc;
      @(posedge CLOCK) disable iff (RST)
      core_trip |=> !CORE_SWITCH_ENABLE && !POWER_GOOD_OUT && EXT_PHASE_THREE_DRIVE != PHASE_DRIVE_RUN;
   endproperty
   a_core_oc: assert property (p_core_oc) else $error("core overcurrent not shut");

   property p_nb_only;
      @(posedge CLOCK) disable iff (RST)
      nb_shut && !core_shut && state == ST_RUN && next_state == ST_RUN && !core_trip |=> CORE_SWITCH_ENABLE;
   endproperty
   a_nb_only: assert property (p_nb_only) else $error("core disabled by bridge fault");

   property p_sense_open;
      @(posedge CLOCK) disable iff (RST)
      OPEN_SENSE |=> !CORE_SWITCH_ENABLE && !NB_SWITCH_ENABLE;
   endproperty
   a_sense_open: assert property (p_sense_open) else $error("running with open sense");

   property p_pg_ss;
      @(posedge CLOCK) disable iff (RST)
      state == ST_SOFTSTART |-> !POWER_GOOD_OUT;
   endproperty
   a_pg_ss: assert property (p_pg_ss) else $error("good during soft-start");

   property p_prepor;
      @(posedge CLOCK) disable iff (RST)
      !DRIVER_SUPPLY_OK |=> PRE_POR_OVP_ENABLE;
   endproperty
   a_prepor: assert property (p_prepor) else $error("pre-reset path off");

   property p_exh_latch;
      @(posedge CLOCK) disable iff (RST)
      (core_exh || nb_exh) && MAIN_POR_OK |=> !CORE_SWITCH_ENABLE && !NB_SWITCH_ENABLE;
   endproperty
   a_exh_latch: assert property (p_exh_latch) else $error("retries exhausted but driving");

   property p_ov_needs_both;
      @(posedge CLOCK) disable iff (RST)
      CORE_OVERVOLTAGE_TRIP && !CORE_ABOVE_PG_UPPER && !core_clamp |=> !CORE_LOW_SIDE_FORCE_ON;
   endproperty
   a_ov_needs_both: assert property (p_ov_needs_both) else $error("clamp without both comparators");

   property p_ov_ext_low;
      @(posedge CLOCK) disable iff (RST)
      core_ov && PHASE_THREE_ACTIVE |=> EXT_PHASE_THREE_DRIVE == PHASE_DRIVE_LOW;
   endproperty
   a_ov_ext_low: assert property (p_ov_ext_low) else $error("external drive not low in overvoltage");

   property p_nominal_trip;
      @(posedge CLOCK) disable iff (RST)
      state == ST_RUN && !core_shut && CORE_CURRENT_ABOVE_100UA |=> !CORE_SWITCH_ENABLE;
   endproperty
   a_nominal_trip: assert property (p_nominal_trip) else $error("nominal overcurrent ignored");

   property p_raised_level;
      @(posedge CLOCK) disable iff (RST)
      in_ss && !CORE_SS_DONE && !core_shut && !CORE_CURRENT_ABOVE_140UA |=> !core_shut;
   endproperty
   a_raised_level: assert property (p_raised_level) else $error("trip below raised level");

   property p_nb_oc;
      @(posedge CLOCK) disable iff (RST)
      nb_trip |=> !NB_SWITCH_ENABLE && !POWER_GOOD_OUT;
   endproperty
   a_nb_oc: assert property (p_nb_oc) else $error("bridge overcurrent not shut");
endmodule
`default_nettype wire

/* File: rail_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rail_stage_model #(
   parameter int SS_CYCLES = 4
) (
   // Commands from the block
   input wire logic clk,
   input wire logic switch_en,
   input wire logic ss_req,
   // Load set by the bench
   input wire logic [1:0] load_level,
   // Feedback to the block
   output logic ss_done,
   output logic above_100,
   output logic above_140
);
   int ramp = 0;
   // Ramp completes a fixed time after the request, collapses when stage is off
   always @(posedge clk) begin
      if (!switch_en && !ss_req)
         ramp <= 0;
      else if (ss_req && ramp < SS_CYCLES)
         ramp <= ramp + 1;
   end
   assign ss_done = (ramp >= SS_CYCLES);
   // Current only flows while the stage is driven
   assign above_100 = (switch_en || ss_req) && (load_level != 2'h0);
   assign above_140 = (switch_en || ss_req) && (load_level == 2'h2);
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fault_pkg::*;
   localparam int WAIT_CYCLES = 20;
   localparam int W = WAIT_CYCLES;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic MAIN_POR_OK = 1'b0, DRIVER_SUPPLY_OK = 1'b0, ENABLE = 1'b0, OPEN_SENSE = 1'b0;
   logic CORE_OVERVOLTAGE_TRIP = 1'b0, CORE_ABOVE_PG_UPPER = 1'b0, CORE_DIFF_ABOVE_400MV = 1'b0;
   logic CORE_BELOW_UV = 1'b0, CORE_ABOVE_UV_RELEASE = 1'b1;
   logic NB_OVERVOLTAGE_TRIP = 1'b0, NB_ABOVE_PG_UPPER = 1'b0, NB_DIFF_ABOVE_400MV = 1'b0;
   logic NB_BELOW_UV = 1'b0, NB_ABOVE_UV_RELEASE = 1'b1;
   logic PHASE_THREE_ACTIVE = 1'b1, PHASE_FOUR_ACTIVE = 1'b1;
   logic CORE_SS_DONE, NB_SS_DONE;
   logic CORE_CURRENT_ABOVE_100UA, CORE_CURRENT_ABOVE_140UA, NB_CURRENT_ABOVE_100UA, NB_CURRENT_ABOVE_140UA;
   logic CORE_SWITCH_ENABLE, CORE_LOW_SIDE_FORCE_ON, NB_SWITCH_ENABLE, NB_LOW_SIDE_FORCE_ON;
   logic [1:0] EXT_PHASE_THREE_DRIVE, EXT_PHASE_FOUR_DRIVE;
   logic CORE_SOFT_START_REQ, NB_SOFT_START_REQ, PRE_POR_OVP_ENABLE, POWER_GOOD_OUT;
   logic [1:0] core_load = 2'h0;
   logic [1:0] nb_load = 2'h0;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int r;

   regulator_fault_protection #(.WAIT_CYCLES(WAIT_CYCLES)) regulator_fault_protection_inst (
      .CLOCK(CLOCK), .RST(RST), .MAIN_POR_OK(MAIN_POR_OK), .DRIVER_SUPPLY_OK(DRIVER_SUPPLY_OK), .ENABLE(ENABLE),
      .CORE_SS_DONE(CORE_SS_DONE), .NB_SS_DONE(NB_SS_DONE),
      .CORE_OVERVOLTAGE_TRIP(CORE_OVERVOLTAGE_TRIP), .CORE_ABOVE_PG_UPPER(CORE_ABOVE_PG_UPPER),
      .CORE_DIFF_ABOVE_400MV(CORE_DIFF_ABOVE_400MV), .CORE_BELOW_UV(CORE_BELOW_UV),
      .CORE_ABOVE_UV_RELEASE(CORE_ABOVE_UV_RELEASE), .NB_OVERVOLTAGE_TRIP(NB_OVERVOLTAGE_TRIP),
      .NB_ABOVE_PG_UPPER(NB_ABOVE_PG_UPPER), .NB_DIFF_ABOVE_400MV(NB_DIFF_ABOVE_400MV), .NB_BELOW_UV(NB_BELOW_UV),
      .NB_ABOVE_UV_RELEASE(NB_ABOVE_UV_RELEASE), .OPEN_SENSE(OPEN_SENSE),
      .CORE_CURRENT_ABOVE_100UA(CORE_CURRENT_ABOVE_100UA), .CORE_CURRENT_ABOVE_140UA(CORE_CURRENT_ABOVE_140UA),
      .NB_CURRENT_ABOVE_100UA(NB_CURRENT_ABOVE_100UA), .NB_CURRENT_ABOVE_140UA(NB_CURRENT_ABOVE_140UA),
      .PHASE_THREE_ACTIVE(PHASE_THREE_ACTIVE), .PHASE_FOUR_ACTIVE(PHASE_FOUR_ACTIVE),
      .CORE_SWITCH_ENABLE(CORE_SWITCH_ENABLE), .CORE_LOW_SIDE_FORCE_ON(CORE_LOW_SIDE_FORCE_ON),
      .NB_SWITCH_ENABLE(NB_SWITCH_ENABLE), .NB_LOW_SIDE_FORCE_ON(NB_LOW_SIDE_FORCE_ON),
      .EXT_PHASE_THREE_DRIVE(EXT_PHASE_THREE_DRIVE), .EXT_PHASE_FOUR_DRIVE(EXT_PHASE_FOUR_DRIVE),
      .CORE_SOFT_START_REQ(CORE_SOFT_START_REQ), .NB_SOFT_START_REQ(NB_SOFT_START_REQ),
      .PRE_POR_OVP_ENABLE(PRE_POR_OVP_ENABLE), .POWER_GOOD_OUT(POWER_GOOD_OUT));
   rail_stage_model core_stage (.clk(CLOCK), .switch_en(CORE_SWITCH_ENABLE), .ss_req(CORE_SOFT_START_REQ),
      .load_level(core_load), .ss_done(CORE_SS_DONE), .above_100(CORE_CURRENT_ABOVE_100UA),
      .above_140(CORE_CURRENT_ABOVE_140UA));
   rail_stage_model nb_stage (.clk(CLOCK), .switch_en(NB_SWITCH_ENABLE), .ss_req(NB_SOFT_START_REQ),
      .load_level(nb_load), .ss_done(NB_SS_DONE), .above_100(NB_CURRENT_ABOVE_100UA),
      .above_140(NB_CURRENT_ABOVE_140UA));

   initial begin
      forever #25 CLOCK = ~CLOCK;
   end

   task finish_test;
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         finish_test();
      end
   end

   task look(input int n);
      repeat (n) @(negedge CLOCK);
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
         err_count = err_count + 1;
      end
   endtask

   // Counts restart requests of one rail over a span of cycles
   task retries(input logic nb, input int span, output int n);
      logic prev;
      prev = 1'b0;
      n = 0;
      repeat (span) begin
         @(negedge CLOCK);
         if ((nb ? NB_SOFT_START_REQ : CORE_SOFT_START_REQ) === 1'b1 && !prev)
            n = n + 1;
         prev = nb ? NB_SOFT_START_REQ : CORE_SOFT_START_REQ;
      end
   endtask

   task por_toggle;
      @(posedge CLOCK);
      MAIN_POR_OK <= 1'b0;
      look(3);
      @(posedge CLOCK);
      MAIN_POR_OK <= 1'b1;
      look(25);
      chk(POWER_GOOD_OUT, 1'b1, "good after power-on");
   endtask

   task t_reset_and_start;
      chk(CORE_SWITCH_ENABLE, 1'b0, "reset switch");
      chk(EXT_PHASE_THREE_DRIVE, PHASE_DRIVE_HIZ, "reset ext drive");
      chk(PRE_POR_OVP_ENABLE, 1'b1, "reset pre-por");
      chk(POWER_GOOD_OUT, 1'b0, "reset good");
      @(posedge CLOCK);
      RST <= 1'b0;
      MAIN_POR_OK <= 1'b1;
      DRIVER_SUPPLY_OK <= 1'b1;
      ENABLE <= 1'b1;
      look(3);
      chk(CORE_SOFT_START_REQ, 1'b1, "soft-start begins");
      chk(POWER_GOOD_OUT, 1'b0, "good low in soft-start");
      look(20);
      chk(POWER_GOOD_OUT, 1'b1, "good after soft-start");
      chk(NB_SWITCH_ENABLE, 1'b1, "nb running");
      chk(PRE_POR_OVP_ENABLE, 1'b0, "pre-por off");
   endtask

   task t_undervoltage;
      @(posedge CLOCK);
      CORE_BELOW_UV <= 1'b1;
      CORE_ABOVE_UV_RELEASE <= 1'b0;
      look(3);
      chk(POWER_GOOD_OUT, 1'b0, "uv good");
      chk(CORE_SWITCH_ENABLE, 1'b1, "uv no shutdown");
      @(posedge CLOCK);
      CORE_BELOW_UV <= 1'b0;
      look(3);
      chk(POWER_GOOD_OUT, 1'b0, "good in hysteresis band");
      @(posedge CLOCK);
      CORE_ABOVE_UV_RELEASE <= 1'b1;
      look(3);
      chk(POWER_GOOD_OUT, 1'b1, "good released");
   endtask

   task t_core_hiccup;
      @(posedge CLOCK);
      core_load <= 2'h1;
      look(3);
      chk(CORE_SWITCH_ENABLE, 1'b0, "oc core off");
      chk(EXT_PHASE_THREE_DRIVE, PHASE_DRIVE_HIZ, "oc phase three");
      chk(EXT_PHASE_FOUR_DRIVE, PHASE_DRIVE_HIZ, "oc phase four");
      chk(POWER_GOOD_OUT, 1'b0, "oc good");
      chk(NB_SWITCH_ENABLE, 1'b1, "nb unaffected");
      look(W - 3);
      chk(CORE_SOFT_START_REQ, 1'b0, "still waiting");
      look(4);
      chk(CORE_SOFT_START_REQ, 1'b1, "retry after wait");
      retries(1'b0, 12 * (W + 12), r);
      chk(r >= 9, 1'b1, "continuous hiccup");
      chk(NB_SWITCH_ENABLE, 1'b1, "no latch in hiccup");
      @(posedge CLOCK);
      core_load <= 2'h0;
      look(W + 30);
      chk(POWER_GOOD_OUT, 1'b1, "recovered");
   endtask

   // Fault above the raised level fails every retry until latch-off
   task t_latch(input logic nb);
      @(posedge CLOCK);
      if (nb)
         nb_load <= 2'h2;
      else
         core_load <= 2'h2;
      look(3);
      chk(nb ? CORE_SWITCH_ENABLE : NB_SWITCH_ENABLE, 1'b1, "other rail runs");
      retries(nb, 10 * (W + 12), r);
      chk(r, 7, "retry count");
      chk(CORE_SWITCH_ENABLE, 1'b0, "core latched");
      chk(NB_SWITCH_ENABLE, 1'b0, "nb latched");
      @(posedge CLOCK);
      ENABLE <= 1'b0;
      core_load <= 2'h0;
      nb_load <= 2'h0;
      look(2);
      @(posedge CLOCK);
      ENABLE <= 1'b1;
      look(W + 10);
      chk(CORE_SOFT_START_REQ, 1'b0, "latch beats enable");
      por_toggle();
   endtask

   task ov(input logic v);
      @(posedge CLOCK);
      CORE_ABOVE_PG_UPPER <= v;
      CORE_OVERVOLTAGE_TRIP <= v;
      CORE_DIFF_ABOVE_400MV <= v;
      look(3);
   endtask

   task t_overvoltage;
      @(posedge CLOCK);
      CORE_OVERVOLTAGE_TRIP <= 1'b1;
      look(3);
      chk(CORE_LOW_SIDE_FORCE_ON, 1'b0, "trip alone");
      ov(1'b1);
      chk(CORE_LOW_SIDE_FORCE_ON, 1'b1, "clamp on");
      chk(EXT_PHASE_THREE_DRIVE, PHASE_DRIVE_LOW, "ov phase three");
      chk(EXT_PHASE_FOUR_DRIVE, PHASE_DRIVE_LOW, "ov phase four");
      chk(POWER_GOOD_OUT, 1'b0, "ov good");
      chk(CORE_SWITCH_ENABLE, 1'b0, "ov switching off");
      @(posedge CLOCK);
      CORE_OVERVOLTAGE_TRIP <= 1'b0;
      CORE_ABOVE_PG_UPPER <= 1'b0;
      look(3);
      chk(CORE_LOW_SIDE_FORCE_ON, 1'b1, "clamp held");
      ov(1'b0);
      chk(CORE_LOW_SIDE_FORCE_ON, 1'b0, "clamp released");
      ov(1'b1);
      chk(CORE_LOW_SIDE_FORCE_ON, 1'b1, "clamp on recurrence");
      ov(1'b0);
      @(posedge CLOCK);
      NB_OVERVOLTAGE_TRIP <= 1'b1;
      NB_ABOVE_PG_UPPER <= 1'b1;
      NB_DIFF_ABOVE_400MV <= 1'b1;
      look(3);
      chk(NB_LOW_SIDE_FORCE_ON, 1'b1, "nb clamp on");
      @(posedge CLOCK);
      NB_OVERVOLTAGE_TRIP <= 1'b0;
      NB_ABOVE_PG_UPPER <= 1'b0;
      NB_DIFF_ABOVE_400MV <= 1'b0;
      look(3);
      chk(NB_LOW_SIDE_FORCE_ON, 1'b0, "nb clamp released");
      look(W + 10);
      chk(CORE_SOFT_START_REQ, 1'b0, "ov stays latched");
      por_toggle();
   endtask

   task t_open_sense_and_supply;
      @(posedge CLOCK);
      OPEN_SENSE <= 1'b1;
      look(5);
      chk(CORE_SWITCH_ENABLE | NB_SWITCH_ENABLE | CORE_SOFT_START_REQ, 1'b0, "open sense off");
      @(posedge CLOCK);
      OPEN_SENSE <= 1'b0;
      look(3);
      chk(CORE_SOFT_START_REQ, 1'b1, "restart after open sense");
      look(20);
      chk(POWER_GOOD_OUT, 1'b1, "good after restart");
      @(posedge CLOCK);
      DRIVER_SUPPLY_OK <= 1'b0;
      look(3);
      chk(PRE_POR_OVP_ENABLE, 1'b1, "pre-por back on");
      chk(POWER_GOOD_OUT, 1'b0, "good low without supply");
   endtask

   initial begin
      repeat (16) @(posedge CLOCK);
      look(1);
      t_reset_and_start();
      t_undervoltage();
      t_core_hiccup();
      t_latch(1'b0);
      t_latch(1'b1);
      t_overvoltage();
      t_open_sense_and_supply();
      finish_test();
   end
endmodule
`default_nettype wire
